/* File: verilog/sspi_port.sv */
// Synchronous serial port, SPI role, with APB registers
`timescale 1ns/1ps
module sspi_port
  import sspi_pkg::*;
#(
  parameter int DATA_BITS = 8
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timerTwoOutput,
  input  wire logic        serialClockIn,
  output logic             serialClockOut,
  output logic             serialClockOe,
  output logic             serialOutPin,
  output logic             serialOutOe,
  input  wire logic        serialInPin,
  input  wire logic        slaveSelectN,
  output logic             portPinsOwned,
  output logic             i2cClockHoldLow,
  output logic             portInterruptFlag
);
  logic [7:0]          control_reg;
  logic [7:0]          control_next;
  logic [DATA_BITS-1:0] shiftRegister_reg;
  logic [DATA_BITS-1:0] rxTxBuffer_reg;
  logic [7:0]          slaveAddress_reg;
  logic [3:0]          bitCount_reg;
  logic                bufferFull_reg;
  logic                intFlag_reg;
  logic                dataAddr_reg;
  logic                stopSeen_reg;
  logic                startSeen_reg;
  logic                readWrite_reg;
  logic                addrUpdate_reg;
  logic                sclkPrev_reg;
  logic                sclkOut_reg;
  logic                sampledIn_reg;
  sspi_state_t         state_reg;
  wire                 wrStatus;
  wire                 wrControl;
  wire                 wrBuffer;
  wire                 wrSlvAdr;
  wire                 rdBuffer;
  wire                 rdEvent;
  wire                 halfTick;
  wire [3:0]           mode;
  wire                 portEnable;
  wire                 clockPolarity;
  wire                 isMaster;
  wire                 isSlave;
  wire                 isI2c;
  wire                 slaveSelected;
  wire                 busy;
  wire                 lostWrite;
  wire                 leadEdge;
  wire                 trailEdge;
  wire                 sampleEdge;
  wire                 shiftEdge;
  wire                 byteDone;
  wire                 overflow;
  wire [7:0]           statusValue;
  wire                 sclkIdle;
  wire                 sclkRise;
  wire                 sclkFall;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  sspi_apb sspi_apb_inst (
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pready    (pready),
    .pslverr   (pslverr),
    .wrStatus  (wrStatus),
    .wrControl (wrControl),
    .wrBuffer  (wrBuffer),
    .wrSlvAdr  (wrSlvAdr),
    .rdBuffer  (rdBuffer),
    .rdEvent   (rdEvent)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign mode          = control_reg[3:0];
  assign portEnable    = control_reg[SSPI_CTL_EN];
  assign clockPolarity = control_reg[SSPI_CTL_CKP];
  assign isMaster      = portEnable && (mode <= SSPI_M_TMR);
  // slave codes, select honoured only in mode 4
  assign isSlave       = portEnable && ((mode == SSPI_M_SLV_SS) || (mode == SSPI_M_SLV));
  assign slaveSelected = (mode == SSPI_M_SLV) || !slaveSelectN;
  assign isI2c         = portEnable && ((mode == SSPI_M_I2C7) || (mode == SSPI_M_I2C10) ||
                         (mode == SSPI_M_FWM) || (mode == SSPI_M_FWM7) || (mode == SSPI_M_FWM10));
  assign busy          = (isMaster && (state_reg != SSPI_IDLE)) || (isSlave && (bitCount_reg != 4'h0));
  assign lostWrite     = wrBuffer && busy;

  // ----------------------------------------
  // Master clock generation
  // ----------------------------------------
  sspi_clkdiv sspi_clkdiv_inst (
    .clk       (clk),
    .reset     (reset),
    .run       (isMaster && (state_reg != SSPI_IDLE)),
    .mode      (mode),
    .timerTick (timerTwoOutput),
    .halfTick  (halfTick)
  );

  // ----------------------------------------
  // Edge detection: sample on leading, shift on trailing
  // ----------------------------------------
  assign sclkRise   = serialClockIn && !sclkPrev_reg;
  assign sclkFall   = !serialClockIn && sclkPrev_reg;
  assign leadEdge   = isMaster ? (halfTick && (state_reg == SSPI_LEAD)) :
                      (isSlave && slaveSelected && (clockPolarity ? sclkFall : sclkRise));
  assign trailEdge  = isMaster ? (halfTick && (state_reg == SSPI_TRAIL)) :
                      (isSlave && slaveSelected && (clockPolarity ? sclkRise : sclkFall));
  assign sampleEdge = leadEdge;
  assign shiftEdge  = trailEdge;
  assign byteDone   = sampleEdge && (bitCount_reg == (SSPI_BITS - 4'h1));
  assign overflow   = byteDone && isSlave && bufferFull_reg;
  assign sclkIdle   = clockPolarity;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_comb begin
    control_next = control_reg;
    if (wrControl) begin
      control_next = pwdata[7:0];
    end
    if (lostWrite) begin
      control_next[SSPI_CTL_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (overflow || (isI2c && 1'b0)) begin
      control_next[SSPI_CTL_OVF] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      control_reg <= SSPI_CTRL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  // ----------------------------------------
  // Master sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !isMaster) begin
      state_reg   <= SSPI_IDLE;
      sclkOut_reg <= 1'b0;
    end else begin
      case (state_reg)
        SSPI_IDLE: begin
          sclkOut_reg <= sclkIdle;
          if (wrBuffer) begin
            state_reg <= SSPI_LEAD;
          end
        end
        SSPI_LEAD: begin
          if (halfTick) begin
            sclkOut_reg <= !sclkIdle;
            state_reg   <= SSPI_TRAIL;
          end
        end
        SSPI_TRAIL: begin
          if (halfTick) begin
            sclkOut_reg <= sclkIdle;
            state_reg   <= (bitCount_reg == 4'h0) ? SSPI_IDLE : SSPI_LEAD;
          end
        end
        default: state_reg <= SSPI_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Shift path
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      shiftRegister_reg <= '0;
      bitCount_reg      <= 4'h0;
      sampledIn_reg     <= 1'b0;
      sclkPrev_reg      <= 1'b0;
    end else begin
      sclkPrev_reg <= serialClockIn;
      if (!portEnable) begin
        bitCount_reg <= 4'h0;
      end else if (wrBuffer && !busy) begin
        shiftRegister_reg <= pwdata[DATA_BITS-1:0];
      end else begin
        // MSB first, in and out together
        if (sampleEdge) begin
          sampledIn_reg <= serialInPin;
          bitCount_reg  <= byteDone ? 4'h0 : bitCount_reg + 4'h1;
        end
        // Data out only moves on trailing edges, so it holds while sampled
        if (shiftEdge) begin
          shiftRegister_reg <= {shiftRegister_reg[DATA_BITS-2:0], sampledIn_reg};
        end
      end
    end
  end

  // ----------------------------------------
  // Receive buffer and flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rxTxBuffer_reg <= '0;
      bufferFull_reg <= 1'b0;
      intFlag_reg    <= 1'b0;
    end else begin
      if (rdEvent) begin
        intFlag_reg <= 1'b0;
      end
      if (rdBuffer) begin
        bufferFull_reg <= 1'b0;
      end
      if (byteDone) begin
        intFlag_reg <= 1'b1;
        if (!overflow) begin
          rxTxBuffer_reg <= {shiftRegister_reg[DATA_BITS-2:0], serialInPin};
          bufferFull_reg <= 1'b1;
        end
      end
      if (isI2c && wrBuffer) begin
        rxTxBuffer_reg <= pwdata[DATA_BITS-1:0];
        bufferFull_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // I2C status bits, engine not present
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !portEnable) begin
      stopSeen_reg     <= 1'b0;
      startSeen_reg    <= 1'b0;
      dataAddr_reg     <= 1'b0;
      readWrite_reg    <= 1'b0;
      addrUpdate_reg   <= 1'b0;
      slaveAddress_reg <= 8'h00;
    end else if (wrSlvAdr) begin
      slaveAddress_reg <= pwdata[7:0];
      addrUpdate_reg   <= 1'b0;
    end
  end

  assign statusValue = {2'b00, dataAddr_reg, stopSeen_reg, startSeen_reg,
                        readWrite_reg, addrUpdate_reg, bufferFull_reg};

  // ----------------------------------------
  // Read data and pins
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        SSPI_ADDR_STATUS:  prdata <= {24'h000000, statusValue};
        SSPI_ADDR_CONTROL: prdata <= {24'h000000, control_reg};
        SSPI_ADDR_BUFFER:  prdata <= {{(32-DATA_BITS){1'b0}}, rxTxBuffer_reg};
        SSPI_ADDR_SLVADR:  prdata <= {24'h000000, slaveAddress_reg};
        SSPI_ADDR_I2CEVT:  prdata <= {31'h00000000, intFlag_reg};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  assign portPinsOwned     = portEnable;
  assign serialClockOut    = (isMaster && (state_reg != SSPI_IDLE)) ? sclkOut_reg : sclkIdle;
  assign serialClockOe     = isMaster;
  assign serialOutPin      = shiftRegister_reg[DATA_BITS-1];
  assign serialOutOe       = isMaster || (isSlave && slaveSelected);
  assign i2cClockHoldLow   = isI2c && !clockPolarity;
  assign portInterruptFlag = intFlag_reg;
endmodule

/* File: verilog/sspi_pkg.sv */
// Package of constants for the synchronous serial port in SPI role
// Function
// - Modes 0-3: master, osc/4,/16,/64, timer/4
// - Mode 4 slave with select, 5 without
// - Modes 6,7: I2C slave 7/10-bit
// - Modes 11,14,15 firmware master; others reserved
// - Enable hands pins to port
// - SPI polarity one idles clock high
// - I2C polarity bit releases or stretches clock
// - Busy buffer write discarded, sets collision flag
// - Slave overflow sets flag, drops new byte
// - Master mode never sets overflow flag
// - I2C full buffer receive sets overflow; here I2C modes never set it
// - Eight bits shifted MSB first, full duplex
// - Eighth bit loads buffer, sets full, interrupt
// - Buffer read clears full flag
// - I2C transmit: full while transmitting
// - Data/address flag shows last byte kind; held at zero here
// - Stop flag cleared on reset, disable
// - Start flag cleared on reset, disable
// - Direction flag holds last address R/W; held at zero here
// - Address-update flag for 10-bit slave; held at zero here
// - Master drives clock; slave clock is input
// - Master buffer write starts one byte
// - Reset disables port, abandons transfer
package sspi_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] SSPI_ADDR_STATUS  = 12'h000;
  localparam logic [11:0] SSPI_ADDR_CONTROL = 12'h004;
  localparam logic [11:0] SSPI_ADDR_BUFFER  = 12'h008;
  localparam logic [11:0] SSPI_ADDR_SLVADR  = 12'h00c;
  localparam logic [11:0] SSPI_ADDR_I2CEVT  = 12'h010;
  localparam logic [7:0]  SSPI_CTRL_RESET   = 8'h00;
  // ----------------------------------------
  // Control and status fields
  // ----------------------------------------
  localparam int SSPI_CTL_WRITE_COLLISION_FLAG = 7;
  localparam int SSPI_CTL_OVF  = 6;
  localparam int SSPI_CTL_EN   = 5;
  localparam int SSPI_CTL_CKP  = 4;
  localparam int SSPI_ST_DA    = 5;
  localparam int SSPI_ST_STOP  = 4;
  localparam int SSPI_ST_START = 3;
  localparam int SSPI_ST_RW    = 2;
  localparam int SSPI_ST_UA    = 1;
  localparam int SSPI_ST_BF    = 0;
  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [3:0] SSPI_M_DIV4    = 4'h0;
  localparam logic [3:0] SSPI_M_DIV16   = 4'h1;
  localparam logic [3:0] SSPI_M_DIV64   = 4'h2;
  localparam logic [3:0] SSPI_M_TMR     = 4'h3;
  localparam logic [3:0] SSPI_M_SLV_SS  = 4'h4;
  localparam logic [3:0] SSPI_M_SLV     = 4'h5;
  localparam logic [3:0] SSPI_M_I2C7    = 4'h6;
  localparam logic [3:0] SSPI_M_I2C10   = 4'h7;
  localparam logic [3:0] SSPI_M_FWM     = 4'hb;
  localparam logic [3:0] SSPI_M_FWM7    = 4'he;
  localparam logic [3:0] SSPI_M_FWM10   = 4'hf;
  // ----------------------------------------
  // Timing: bit rate divisors in core cycles
  // ----------------------------------------
  localparam logic [6:0] SSPI_DIV4  = 7'h04;
  localparam logic [6:0] SSPI_DIV16 = 7'h10;
  localparam logic [6:0] SSPI_DIV64 = 7'h40;
  localparam logic [3:0] SSPI_BITS  = 4'h8;
  typedef enum logic [1:0] {SSPI_IDLE, SSPI_LEAD, SSPI_TRAIL} sspi_state_t;
endpackage

/* File: verilog/sspi_clkdiv.sv */
// Bit-rate enable generator for master mode
`timescale 1ns/1ps
module sspi_clkdiv
  import sspi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [3:0] mode,
  input  wire logic       timerTick,
  output logic            halfTick
);
  logic [6:0] count_reg;
  logic       timerHalf_reg;
  wire  [6:0] period;
  wire        countDone;

  // ----------------------------------------
  // Clock select
  // ----------------------------------------
  // rate selection
  assign period    = (mode == SSPI_M_DIV4)  ? SSPI_DIV4 :
                     (mode == SSPI_M_DIV16) ? SSPI_DIV16 : SSPI_DIV64;
  assign countDone = (count_reg == ((period >> 1) - 7'h01));
  // Half period elapsed: one edge of the serial clock
  assign halfTick  = run && ((mode == SSPI_M_TMR) ? (timerTick && timerHalf_reg) : countDone);

  always_ff @(posedge clk) begin
    if (reset || !run) begin
      count_reg     <= 7'h00;
      timerHalf_reg <= 1'b0;
    end else begin
      count_reg <= countDone ? 7'h00 : count_reg + 7'h01;
      if (timerTick) begin
        timerHalf_reg <= !timerHalf_reg;
      end
    end
  end
endmodule

/* File: verilog/sspi_apb.sv */
// APB slave decode for the serial port registers
`timescale 1ns/1ps
module sspi_apb
  import sspi_pkg::*;
(
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             pready,
  output logic             pslverr,
  output logic             wrStatus,
  output logic             wrControl,
  output logic             wrBuffer,
  output logic             wrSlvAdr,
  output logic             rdBuffer,
  output logic             rdEvent
);
  wire access;
  wire mapped;

  assign access    = psel && penable;
  assign mapped    = (paddr == SSPI_ADDR_STATUS) || (paddr == SSPI_ADDR_CONTROL) ||
                     (paddr == SSPI_ADDR_BUFFER) || (paddr == SSPI_ADDR_SLVADR) ||
                     (paddr == SSPI_ADDR_I2CEVT);
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;
  assign wrStatus  = 1'b0;
  assign wrControl = access && pwrite && (paddr == SSPI_ADDR_CONTROL);
  assign wrBuffer  = access && pwrite && (paddr == SSPI_ADDR_BUFFER);
  assign wrSlvAdr  = access && pwrite && (paddr == SSPI_ADDR_SLVADR);
  assign rdBuffer  = access && !pwrite && (paddr == SSPI_ADDR_BUFFER);
  assign rdEvent   = access && !pwrite && (paddr == SSPI_ADDR_I2CEVT);
endmodule

/* File: sim/sspi_port_assertions.sv */
// Concurrent checks on the serial port top-level ports
`timescale 1ns/1ps
module sspi_port_checker
  import sspi_pkg::*;
#(
  parameter int DATA_BITS = 8
)
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timerTwoOutput,
  input wire logic        serialClockIn,
  input wire logic        serialClockOut,
  input wire logic        serialClockOe,
  input wire logic        serialOutPin,
  input wire logic        serialOutOe,
  input wire logic        serialInPin,
  input wire logic        slaveSelectN,
  input wire logic        portPinsOwned,
  input wire logic        i2cClockHoldLow,
  input wire logic        portInterruptFlag
);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  wire acc;
  assign acc = psel && penable;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence bufWrite;
    acc && pwrite && paddr == SSPI_ADDR_BUFFER && serialClockOe;
  endsequence
  sequence clkMoves;
    $changed(serialClockOut);
  endsequence
  reset_off_a: assert property ($fell(reset) |-> !portPinsOwned && !serialClockOe && prdata == 32'h0)
    else $error("port not idle after reset");
  own_clock_a: assert property (serialClockOe |-> portPinsOwned && serialOutOe)
    else $error("clock driven without port ownership");
  own_out_a: assert property (serialOutOe |-> portPinsOwned)
    else $error("data out driven while port disabled");
  hold_low_a: assert property (i2cClockHoldLow |-> portPinsOwned && !serialClockOe)
    else $error("clock hold outside i2c mode");
  half_period_a: assert property (serialClockOe && $changed(serialClockOut) |=> $stable(serialClockOut))
    else $error("serial clock half period too short");
  start_clock_a: assert property (bufWrite |-> ##[1:70] clkMoves)
    else $error("buffer write did not start clocking");
  status_top_a: assert property (acc && !pwrite && paddr == SSPI_ADDR_STATUS |-> prdata[31:6] == 26'h0)
    else $error("status upper bits not zero");
  flag_clear_a: assert property (acc && !pwrite && paddr == SSPI_ADDR_I2CEVT |=> !portInterruptFlag)
    else $error("interrupt flag not cleared by read");
endmodule

bind sspi_port sspi_port_checker #(.DATA_BITS(DATA_BITS)) sspi_port_checker_inst (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerTwoOutput(timerTwoOutput),
  .serialClockIn(serialClockIn), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
  .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .serialInPin(serialInPin),
  .slaveSelectN(slaveSelectN), .portPinsOwned(portPinsOwned), .i2cClockHoldLow(i2cClockHoldLow),
  .portInterruptFlag(portInterruptFlag)
);

/* File: sim/sspi_peer.sv */
// SPI peripheral model facing the port in master mode
`timescale 1ns/1ps
module sspi_peer (
  input  wire logic serialClock,
  input  wire logic cpol,
  input  wire logic dataFromPort,
  output logic      dataToPort
);
  // ----------------------------------------
  // Shift logic
  // ----------------------------------------
  logic [7:0] txByte;
  logic [7:0] rxByte;
  int         bitCnt;
  initial dataToPort = 1'b0;
  task load(input logic [7:0] b);
    txByte = b;
    bitCnt = 0;
    dataToPort = b[7];
  endtask
  always @(serialClock) begin
    if (serialClock !== cpol) begin
      rxByte = {rxByte[6:0], dataFromPort};
    end else begin
      txByte = {txByte[6:0], 1'b0};
      bitCnt = bitCnt + 1;
      dataToPort = (bitCnt >= 8) ? ~dataToPort : txByte[7];
    end
  end
endmodule

/* File: sim/tb_sync_serial_port_spi.sv */
// Self-checking bench for the serial port in SPI role
`timescale 1ns/1ps
module tb_sync_serial_port_spi
  import sspi_pkg::*;
;
  // ----------------------------------------
  // Signals, instances and helpers
  // ----------------------------------------
  typedef struct {logic [32:0] exp; logic [32:0] mask; string what;} sspi_note_t;
  logic        clk, reset, psel, penable, pwrite, timerTwoOutput, serialClockIn, tbSdi, slaveSelectN;
  logic        pready, pslverr, serialClockOut, serialClockOe, serialOutPin, serialOutOe, peerSdi;
  logic        portPinsOwned, i2cClockHoldLow, portInterruptFlag, cpol, slvMode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  ctl, lastPb, got, tx, va;
  logic [3:0]  i2cModes [5] = '{SSPI_M_I2C7, SSPI_M_I2C10, SSPI_M_FWM, SSPI_M_FWM7, SSPI_M_FWM10};
  wire         serialInPin;
  integer      seed = 21;
  int          badCount, checkCount;
  sspi_note_t  notes[$];
  sspi_note_t  nt;
  assign serialInPin = slvMode ? tbSdi : peerSdi;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  sspi_port #(.DATA_BITS(8)) sspi_port_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerTwoOutput(timerTwoOutput),
    .serialClockIn(serialClockIn), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
    .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .serialInPin(serialInPin),
    .slaveSelectN(slaveSelectN), .portPinsOwned(portPinsOwned), .i2cClockHoldLow(i2cClockHoldLow),
    .portInterruptFlag(portInterruptFlag));
  sspi_peer sspi_peer_inst (.serialClock(serialClockOut), .cpol(cpol), .dataFromPort(serialOutPin),
    .dataToPort(peerSdi));
  task closeOut;
    $display("Checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check("pready", 33'h0, 33'h1);
      closeOut;
    end
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m, input string w);
    notes.push_back('{e & m, m, w});
    apb(1'b0, a, 32'h0);
  endtask
  task waitFlag;
    int n;
    n = 0;
    while (portInterruptFlag !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      check("interrupt wait", 33'h0, 33'h1);
      closeOut;
    end
  endtask
  task xfer(input logic [7:0] d);
    int n;
    lastPb = 8'($random(seed));
    sspi_peer_inst.load(lastPb);
    apb(1'b1, SSPI_ADDR_BUFFER, {24'h0, d});
    apb(1'b1, SSPI_ADDR_BUFFER, {24'h0, ~d});
    waitFlag;
    check("peer byte", {25'h0, sspi_peer_inst.rxByte}, {25'h0, d});
    n = 0;
    while (serialClockOut !== cpol && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("clock idle", {32'h0, serialClockOut}, {32'h0, cpol});
    rd(SSPI_ADDR_I2CEVT, 33'h1, 33'h1, "irq flag");
  endtask
  task sbyte(input logic [7:0] d, output logic [7:0] g);
    for (int i = 7; i >= 0; i--) begin
      tbSdi <= d[i];
      repeat (4) @(posedge clk);
      g[i] = serialOutPin;
      serialClockIn <= ~cpol;
      repeat (4) @(posedge clk);
      serialClockIn <= cpol;
    end
    tbSdi <= ~d[0];
    repeat (8) @(posedge clk);
  endtask
  // Result monitor for register reads
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      nt = notes.pop_front();
      check(nt.what, {pslverr, prdata} & nt.mask, nt.exp);
    end
  end
  always @(posedge clk) timerTwoOutput <= 1'($random(seed));
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, serialClockIn, tbSdi, cpol, slvMode} = '0;
    {reset, slaveSelectN} = 2'b11;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(SSPI_ADDR_CONTROL, 33'h0, 33'h1ffffffff, "control reset");
    apb(1'b1, SSPI_ADDR_STATUS, 32'hff);
    rd(SSPI_ADDR_STATUS, 33'h0, 33'h1ffffffff, "status ro");
    rd(12'h100, 33'h100000000, 33'h1ffffffff, "unmapped");
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      cpol = 1'($random(seed));
      ctl = {3'b001, cpol, 4'(m)};
      apb(1'b1, SSPI_ADDR_CONTROL, {24'h0, ctl});
      @(posedge clk);
      check("clock oe", {32'h0, serialClockOe}, 33'h1);
      xfer(8'($random(seed)));
      rd(SSPI_ADDR_BUFFER, {25'h0, lastPb}, 33'hff, "rx buffer");
      rd(SSPI_ADDR_STATUS, 33'h0, 33'h1ffffffff, "status empty");
      xfer(8'($random(seed)));
      xfer(8'($random(seed)));
      rd(SSPI_ADDR_CONTROL, {25'h0, ctl | 8'h80}, 33'hff, "master control");
      rd(SSPI_ADDR_BUFFER, {25'h0, lastPb}, 33'hff, "drain");
      $display("master mode %0d done", m);
    end
    slvMode = 1'b1;
    cpol = 1'($random(seed));
    serialClockIn <= cpol;
    ctl = {3'b001, cpol, SSPI_M_SLV};
    apb(1'b1, SSPI_ADDR_CONTROL, {24'h0, ctl});
    tx = 8'($random(seed));
    va = 8'($random(seed));
    apb(1'b1, SSPI_ADDR_BUFFER, {24'h0, tx});
    sbyte(va, got);
    waitFlag;
    check("slave tx", {25'h0, got}, {25'h0, tx});
    rd(SSPI_ADDR_STATUS, 33'h1, 33'h3f, "slave full");
    sbyte(~va, got);
    rd(SSPI_ADDR_CONTROL, {25'h0, ctl | 8'h40}, 33'hff, "overflow");
    rd(SSPI_ADDR_BUFFER, {25'h0, va}, 33'hff, "kept byte");
    rd(SSPI_ADDR_STATUS, 33'h0, 33'h3f, "read clears");
    rd(SSPI_ADDR_I2CEVT, 33'h1, 33'h1, "slave irq");
    apb(1'b1, SSPI_ADDR_CONTROL, {24'h0, 3'b001, cpol, SSPI_M_SLV_SS});
    repeat (2) @(posedge clk);
    check("deselected oe", {32'h0, serialOutOe}, 33'h0);
    sbyte(va, got);
    rd(SSPI_ADDR_STATUS, 33'h0, 33'h1, "ignored byte");
    slaveSelectN <= 1'b0;
    repeat (2) @(posedge clk);
    check("selected oe", {32'h0, serialOutOe}, 33'h1);
    sbyte(va, got);
    waitFlag;
    rd(SSPI_ADDR_BUFFER, {25'h0, va}, 33'hff, "selected byte");
    rd(SSPI_ADDR_I2CEVT, 33'h1, 33'h1, "select irq");
    slvMode = 1'b0;
    $display("slave test done");
    for (int k = 0; k < 10; k++) begin
      cpol = 1'(k);
      apb(1'b1, SSPI_ADDR_CONTROL, {24'h0, 3'b001, cpol, i2cModes[k / 2]});
      @(posedge clk);
      check("clock hold", {32'h0, i2cClockHoldLow}, {32'h0, ~cpol});
      rd(SSPI_ADDR_STATUS, 33'h0, 33'h3e, "i2c flags");
    end
    apb(1'b1, SSPI_ADDR_CONTROL, 32'h0);
    @(posedge clk);
    check("pins owned", {32'h0, portPinsOwned}, 33'h0);
    $display("i2c test done");
    apb(1'b1, SSPI_ADDR_CONTROL, 32'h22);
    apb(1'b1, SSPI_ADDR_BUFFER, 32'h5a);
    repeat (40) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("reset oe", {32'h0, serialClockOe}, 33'h0);
    rd(SSPI_ADDR_CONTROL, 33'h0, 33'h1ffffffff, "reset control");
    $display("reset test done");
    closeOut;
  end
endmodule
